/* bench/afi_chk.sv */
// Checker: timing properties on the fault inhibit ports
`timescale 1ns/10ps
`default_nettype none
module afi_chk
   import afi_pkg::*;
(
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       nrst,
   // Watched inputs
   input wire logic       shortFault,
   input wire logic       commutLost,
   input wire logic       batteryLow,
   input wire logic       modeSelect,
   input wire logic       motionDone,
   // Watched outputs
   input wire logic       bridgeInhibit,
   input wire logic       inhibitOutN,
   input wire logic       inhibitOutOe,
   input wire logic       motionComplete,
   input wire logic       velocityMode,
   input wire logic [2:0] displayCode,
   input wire logic       batteryWarnMsg
);
   // ****
   // Properties
   // ****
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Five edges cover the two-flop sync plus the state register
   sequence s_short;
      shortFault[*5];
   endsequence
   sequence s_battOnly;
      (batteryLow && !bridgeInhibit)[*5];
   endsequence
   a_short_inhibit: assert property (s_short |-> bridgeInhibit)
      else $error("short fault left bridge running");
   a_short_disp: assert property (s_short |-> displayCode == 3'h1)
      else $error("short fault not on display");
   a_commut_inhibit: assert property (commutLost[*5] |-> bridgeInhibit)
      else $error("feedback loss left bridge running");
   a_battery_warning_text_disp: assert property (s_battOnly |-> displayCode == DISP_BATTERY_WARNING_TEXT)
      else $error("battery text not on display");
   a_battery_warning_text_pulse: assert property (batteryWarnMsg |=> !batteryWarnMsg)
      else $error("battery message longer than one cycle");
   a_pin_low: assert property (bridgeInhibit[*2] |-> inhibitOutOe && !inhibitOutN)
      else $error("inhibit pin not pulled low");
   a_pin_free: assert property (!bridgeInhibit[*2] |-> !inhibitOutOe)
      else $error("inhibit pin driven while running");
   a_mode_sel: assert property ((modeSelect[*3] |-> velocityMode)
      and (!modeSelect[*3] |-> !velocityMode))
      else $error("mode output does not follow select");
   a_motion_done: assert property ((motionDone[*3] |-> motionComplete)
      and (!motionDone[*3] |-> !motionComplete))
      else $error("motion complete does not follow input");
endmodule : afi_chk
bind afi_fault_inhibit afi_chk u_chk (.*);
`default_nettype wire

/* bench/afi_plant.sv */
// Plant model: fault comparators, heatsink sensor and pulled-up inhibit line
`timescale 1ns/10ps
`default_nettype none
module afi_plant
   import afi_pkg::*;
(
   // Requested conditions
   input  wire logic [NFLT-1:0] faultReq,
   input  wire logic [7:0]      tempC,
   // Inhibit pin from the block
   input  wire logic            inhibitOutN,
   input  wire logic            inhibitOutOe,
   // Comparator and sensor levels
   output logic                 shortFault,
   output logic                 busUnder,
   output logic                 busOver,
   output logic                 tempAboveHigh,
   output logic                 tempBelowLow,
   output logic                 supplyFault,
   output logic                 commutLost,
   output logic                 batteryLow,
   output logic [7:0]           heatsinkTemp,
   output logic                 inhibitLine
);
   // ****
   // Comparators
   // ****
   assign shortFault    = faultReq[BIT_SHORT];
   assign busUnder      = faultReq[BIT_UNDERV];
   assign busOver       = faultReq[BIT_OVERV];
   assign supplyFault   = faultReq[BIT_SUPPLY];
   assign commutLost    = faultReq[BIT_COMMUT];
   assign batteryLow    = faultReq[BIT_BATTERY];
   // Two thresholds, so the gap between them exercises hysteresis
   assign tempAboveHigh = tempC > 8'h55;
   assign tempBelowLow  = tempC < 8'h50;
   assign heatsinkTemp  = tempC;
   // Open drain with pull-up: released line reads high
   assign inhibitLine   = inhibitOutOe ? inhibitOutN : 1'b1;
endmodule : afi_plant
`default_nettype wire

/* bench/tb_top.sv */
// Testbench: table of single faults, then hand-written edge cases
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import afi_pkg::*;
;
   typedef struct packed {logic [6:0] f; logic [7:0] t; logic [2:0] d; logic i;} afi_row_s;
   afi_row_s rows [7] = '{'{7'h01, 8'h19, 3'h1, 1'b1}, '{7'h02, 8'h19, 3'h2, 1'b1},
      '{7'h04, 8'h19, 3'h3, 1'b1}, '{7'h08, 8'h5a, 3'h4, 1'b1},
      '{7'h10, 8'h19, 3'h5, 1'b1}, '{7'h20, 8'h19, 3'h6, 1'b1},
      '{7'h40, 8'h19, 3'h7, 1'b0}};
   logic core_clk = 0, nrst = 0, faultReset = 0, modeSelect = 0, motionDone = 0;
   logic [6:0] faultReq = 7'h00;
   logic [7:0] tempC = 8'h19, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, sawMsg = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic shortFault, busUnder, busOver, tempAboveHigh, tempBelowLow, supplyFault;
   logic commutLost, batteryLow, inhibitLine, bridgeInhibit, inhibitOutN, irq;
   logic inhibitOutOe, motionComplete, velocityMode, batteryWarnMsg;
   logic [7:0] heatsinkTemp;
   logic [2:0] displayCode;
   int n_fail = 0, checked = 0, cyc = 0;

   afi_fault_inhibit uut (.*);
   afi_plant plant (.*);

   always #20 core_clk = ~core_clk;
   // Whole run is about 230 cycles; ceiling leaves margin for slow answers
   always @(posedge core_clk) begin
      cyc++;
      if (batteryWarnMsg) sawMsg <= 1'b1;
      if (cyc == 3000) begin
         n_fail++;
         conclude();
      end
   end

   // ****
   // Bus and check tasks
   // ****
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wt
   // Handshakes are sampled at the falling edge, where they are settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic awr;
      logic wrd;
      logic bv;
      logic [1:0] br;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge core_clk);
         awr = s_axi_awready;
         wrd = s_axi_wready;
         bv = s_axi_bvalid;
         br = s_axi_bresp;
         @(posedge core_clk);
         if (awr) s_axi_awvalid <= 1'b0;
         if (wrd) s_axi_wvalid <= 1'b0;
      end while (!bv);
      resp = br;
      s_axi_bready <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic arr;
      logic rv;
      logic [31:0] rdat;
      logic [1:0] rr;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge core_clk);
         arr = s_axi_arready;
         rv = s_axi_rvalid;
         rdat = s_axi_rdata;
         rr = s_axi_rresp;
         @(posedge core_clk);
         if (arr) s_axi_arvalid <= 1'b0;
      end while (!rv);
      rdv = rdat;
      resp = rr;
      s_axi_rready <= 1'b0;
      @(posedge core_clk);
   endtask : rd
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         n_fail++;
      end
   endtask : chk
   task automatic conclude;
      if (n_fail == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   // ****
   // Sequence
   // ****
   initial begin
      wt(2);
      nrst <= 1'b1;
      wt(3);
      chk(bridgeInhibit, 1'b0);
      chk(displayCode, DISP_NONE);
      chk(velocityMode, 1'b0);
      rd(ADDR_CONTROL);
      chk(rdv, 32'h1);
      rd(ADDR_ENABLE);
      chk(rdv, 32'h0);
      wr(ADDR_ENABLE, 32'h7f);
      foreach (rows[k]) begin
         faultReq <= rows[k].f;
         tempC <= rows[k].t;
         wt(5);
         chk(bridgeInhibit, rows[k].i);
         chk(inhibitLine, !rows[k].i);
         chk(displayCode, rows[k].d);
         chk(irq, 1'b1);
         rd(ADDR_CAUSE);
         chk(rdv, rows[k].f & INHIBIT_MASK);
         faultReq <= 7'h00;
         tempC <= 8'h19;
         wt(5);
         chk(bridgeInhibit, rows[k].i);
         faultReset <= 1'b1;
         wt(3);
         faultReset <= 1'b0;
         wr(ADDR_CLEAR, 32'h7f);
         wt(3);
         chk(bridgeInhibit, 1'b0);
         chk(irq, 1'b0);
      end
      chk(sawMsg, 1'b1);
      wr(ADDR_CONTROL, 32'h0);
      tempC <= 8'h5a;
      wt(5);
      tempC <= 8'h52;
      wt(5);
      chk(bridgeInhibit, 1'b1);
      rd(ADDR_TEMP);
      chk(rdv, 32'h52);
      tempC <= 8'h4f;
      wt(5);
      chk(bridgeInhibit, 1'b0);
      wr(ADDR_CLEAR, 32'h7f);
      wr(ADDR_ENABLE, 32'h0);
      faultReq <= 7'h01;
      wt(5);
      chk(irq, 1'b0);
      chk(bridgeInhibit, 1'b1);
      faultReq <= 7'h00;
      wt(5);
      chk(bridgeInhibit, 1'b0);
      wr(8'h20, 32'h1);
      chk(resp, RESP_SLVERR);
      rd(8'h20);
      chk(resp, RESP_SLVERR);
      wr(ADDR_STATUS, 32'h7f);
      chk(resp, RESP_OKAY);
      modeSelect <= 1'b1;
      motionDone <= 1'b1;
      wt(4);
      chk(velocityMode, 1'b1);
      chk(motionComplete, 1'b1);
      conclude();
   end
endmodule : tb_top
`default_nettype wire

/* rtl/afi_fault_inhibit.sv */
// Module: amplifier fault gathering, bridge inhibit and AXI4-Lite registers
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Every enabled fault interrupts the processor; every fault except low battery inhibits the bridge.
// - Cause of the present inhibit stays readable by the host.
// - An active fault shows its code on the display output.
// - Output short circuit inhibits the amplifier.
// - DC bus under or over voltage inhibits the amplifier.
// - Heatsink above upper threshold inhibits the amplifier.
// - Over-temperature inhibit ends only below the lower threshold.
// - Heatsink temperature is readable at any time.
// - Internal supply sum too low or imbalance too high inhibits.
// - Missing commutation feedback inhibits the amplifier.
// - Low battery sends a message and shows battery text, no inhibit.
// - Inhibit output low while inhibited, released otherwise.
// - Motion complete output goes high when motion is complete.
// - Low mode-select means current mode, high means velocity mode.
// - Latch mode keeps the bridge off until a reset, even if clear.
// - Auto restart releases the inhibit once the cause has cleared.
module afi_fault_inhibit
   import afi_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // Comparator and sensor inputs, asynchronous
   input  wire logic        shortFault,
   input  wire logic        busUnder,
   input  wire logic        busOver,
   input  wire logic        tempAboveHigh,
   input  wire logic        tempBelowLow,
   input  wire logic        supplyFault,
   input  wire logic        commutLost,
   input  wire logic        batteryLow,
   input  wire logic [7:0]  heatsinkTemp,
   input  wire logic        modeSelect,
   input  wire logic        motionDone,
   // Reset pushbutton, asynchronous
   input  wire logic        faultReset,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Amplifier side
   output logic             bridgeInhibit,
   output logic             inhibitOutN,
   output logic             inhibitOutOe,
   output logic             motionComplete,
   output logic             velocityMode,
   output logic [2:0]       displayCode,
   output logic             batteryWarnMsg,
   output logic             irq
);

   afi_state_s s_q;
   afi_state_s s_d;

   logic [NFLT-1:0] rawFault;
   logic [NFLT-1:0] live;
   logic [NFLT-1:0] rise;
   logic [NFLT-2:0] faultNow;
   logic [NFLT-1:0] clrBits;
   logic [2:0]      dispNext;
   logic            wrFire;
   logic            rdFire;
   logic            causeClear;
   logic [1:0]      rstSync;
   logic            rstReq;

   assign rawFault = {batteryLow, commutLost, supplyFault, tempAboveHigh,
                      busOver, busUnder, shortFault};

   // ****************************************
   // Reset pushbutton synchroniser
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rstSync <= 2'b00;
      end else begin
         rstSync <= {rstSync[0], faultReset};
      end
   end
   assign rstReq = rstSync[1];

   // ****************************************
   // Handshake outputs
   // ****************************************
   assign s_axi_awready = !s_q.awHeld && !s_q.bValid;
   assign s_axi_wready  = !s_q.wHeld && !s_q.bValid;
   assign s_axi_arready = !s_q.rValid;
   assign s_axi_bvalid  = s_q.bValid;
   assign s_axi_bresp   = s_q.bResp;
   assign s_axi_rvalid  = s_q.rValid;
   assign s_axi_rdata   = s_q.rData;
   assign s_axi_rresp   = s_q.rResp;

   // ****************************************
   // Amplifier outputs
   // ****************************************
   assign bridgeInhibit  = (s_q.mode != RUN);
   assign inhibitOutN    = 1'b0;
   assign inhibitOutOe   = (s_q.mode != RUN);
   assign motionComplete = s_q.doneSync[1];
   assign velocityMode   = s_q.modeSync[1];
   assign displayCode    = s_q.disp;
   assign batteryWarnMsg = s_q.battMsg;
   assign irq            = |(s_q.status & s_q.enable);

   // Over-temperature is held by its own hysteresis state, not the raw pin
   always_comb begin
      live = s_q.sync2;
      live[BIT_OVERT] = s_q.overTemp;
   end

   always_comb begin
      s_d = s_q;
      rise = '0;
      clrBits = '0;
      dispNext = DISP_NONE;
      wrFire = 1'b0;
      rdFire = 1'b0;
      causeClear = 1'b0;

      // Two flops on every comparator input
      s_d.sync1 = rawFault;
      s_d.sync2 = s_q.sync1;
      s_d.lowSync = {s_q.lowSync[0], tempBelowLow};
      s_d.temp1 = heatsinkTemp;
      s_d.temp2 = s_q.temp1;
      s_d.modeSync = {s_q.modeSync[0], modeSelect};
      s_d.doneSync = {s_q.doneSync[0], motionDone};

      // Hysteresis: set above high, cleared only below low
      if (s_q.sync2[BIT_OVERT]) begin
         s_d.overTemp = 1'b1;
      end else if (s_q.lowSync[1]) begin
         s_d.overTemp = 1'b0;
      end

      faultNow = live[NFLT-2:0] & INHIBIT_MASK[NFLT-2:0];

      // Inhibit state machine
      case (s_q.mode)
         RUN: begin
            if (|faultNow) begin
               s_d.mode  = INHIBIT;
               s_d.cause = faultNow;
            end
         end
         INHIBIT: begin
            if (~|faultNow) begin
               if (s_q.latch) begin
                  s_d.mode = WAITCLR;
               end else begin
                  s_d.mode = RUN;
                  causeClear = 1'b1;
               end
            end
         end
         WAITCLR: begin
            if (|faultNow) begin
               s_d.mode = INHIBIT;
            end else if (rstReq || s_q.swRestart) begin
               s_d.mode = RUN;
               causeClear = 1'b1;
            end
         end
         default: begin
            s_d.mode = INHIBIT;
         end
      endcase
      // Cause is frozen until the inhibit ends
      if (causeClear) begin
         s_d.cause = '0;
      end
      s_d.swRestart = 1'b0;

      // Sticky event bits
      rise = live & ~s_q.prevLive;
      s_d.prevLive = live;
      // Battery message pulse and display
      s_d.battPrev = live[BIT_BATTERY];
      s_d.battMsg  = live[BIT_BATTERY] && !s_q.battPrev;

      // Display: first active inhibiting fault, else battery text
      for (int i = NFLT-2; i >= 0; i--) begin
         if (live[i]) begin
            dispNext = 3'(i + 1);
         end
      end
      if (dispNext == DISP_NONE && live[BIT_BATTERY]) begin
         dispNext = DISP_BATTERY_WARNING_TEXT;
      end
      s_d.disp = dispNext;

      // Write channel
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.awHeld = 1'b1;
         s_d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.wHeld = 1'b1;
         s_d.wData = s_axi_wdata;
      end
      if (s_q.awHeld && s_q.wHeld) begin
         wrFire = 1'b1;
         s_d.awHeld = 1'b0;
         s_d.wHeld = 1'b0;
         s_d.bValid = 1'b1;
         s_d.bResp = RESP_OKAY;
         case ({s_q.awAddr[7:2], 2'b00})
            ADDR_CLEAR: begin
               clrBits = s_q.wData[NFLT-1:0];
            end
            ADDR_ENABLE: begin
               s_d.enable = s_q.wData[NFLT-1:0];
            end
            ADDR_CONTROL: begin
               s_d.latch = s_q.wData[0];
               s_d.swRestart = s_q.wData[1];
            end
            ADDR_STATUS, ADDR_CAUSE, ADDR_TEMP, ADDR_LIVE, ADDR_MOTION: begin
               s_d.bResp = RESP_OKAY;
            end
            default: begin
               s_d.bResp = RESP_SLVERR;
            end
         endcase
      end
      if (s_q.bValid && s_axi_bready) begin
         s_d.bValid = 1'b0;
      end
      // Set wins over a clear in the same cycle
      s_d.status = (s_q.status & ~clrBits) | rise;

      // Read channel
      if (s_axi_arvalid && s_axi_arready) begin
         rdFire = 1'b1;
         s_d.rValid = 1'b1;
         s_d.rResp = RESP_OKAY;
         s_d.rData = READ_ZERO;
         case ({s_axi_araddr[7:2], 2'b00})
            ADDR_STATUS:  s_d.rData[NFLT-1:0] = s_q.status;
            ADDR_CLEAR:   s_d.rData = READ_ZERO;
            ADDR_ENABLE:  s_d.rData[NFLT-1:0] = s_q.enable;
            ADDR_CONTROL: s_d.rData[1:0] = {(s_q.mode != RUN), s_q.latch};
            ADDR_CAUSE:   s_d.rData[NFLT-2:0] = s_q.cause;
            ADDR_TEMP:    s_d.rData[7:0] = s_q.temp2;
            ADDR_LIVE:    s_d.rData[NFLT-1:0] = live;
            ADDR_MOTION:  s_d.rData[1:0] = {s_q.modeSync[1], s_q.doneSync[1]};
            default:      s_d.rResp = RESP_SLVERR;
         endcase
      end else if (s_q.rValid && s_axi_rready) begin
         s_d.rValid = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.enable <= ENABLE_RST;
         s_q.latch  <= LATCH_RST;
         s_q.mode   <= RUN;
      end else begin
         s_q <= s_d;
      end
   end

endmodule : afi_fault_inhibit

`default_nettype wire

/* rtl/afi_pkg.sv */
// Package: register map, field layout and state types of the fault inhibit
package afi_pkg;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] ADDR_STATUS  = 8'h00;
   localparam logic [7:0] ADDR_CLEAR   = 8'h04;
   localparam logic [7:0] ADDR_ENABLE  = 8'h08;
   localparam logic [7:0] ADDR_CONTROL = 8'h0c;
   localparam logic [7:0] ADDR_CAUSE   = 8'h10;
   localparam logic [7:0] ADDR_TEMP    = 8'h14;
   localparam logic [7:0] ADDR_LIVE    = 8'h18;
   localparam logic [7:0] ADDR_MOTION  = 8'h1c;

   // ****************************************
   // Fault bit positions
   // ****************************************
   localparam int NFLT         = 7;
   localparam int BIT_SHORT    = 0;
   localparam int BIT_UNDERV   = 1;
   localparam int BIT_OVERV    = 2;
   localparam int BIT_OVERT    = 3;
   localparam int BIT_SUPPLY   = 4;
   localparam int BIT_COMMUT   = 5;
   localparam int BIT_BATTERY  = 6;
   localparam logic [NFLT-1:0] INHIBIT_MASK = 7'h3f;

   // ****************************************
   // Reset values and codes
   // ****************************************
   localparam logic [NFLT-1:0] ENABLE_RST  = 7'h00;
   localparam logic            LATCH_RST   = 1'b1;
   localparam logic [1:0]      RESP_OKAY   = 2'b00;
   localparam logic [1:0]      RESP_SLVERR = 2'b10;
   localparam logic [31:0]     READ_ZERO   = 32'h0000_0000;
   // Display codes: 0 none, 1..6 fault index plus one, 7 battery text
   localparam logic [2:0]      DISP_NONE   = 3'h0;
   localparam logic [2:0]      DISP_BATTERY_WARNING_TEXT   = 3'h7;

   typedef enum logic [1:0] {RUN, INHIBIT, WAITCLR} afi_mode_e;

   typedef struct packed {
      logic [NFLT-1:0] sync1;
      logic [NFLT-1:0] sync2;
      logic [NFLT-1:0] status;
      logic [NFLT-1:0] enable;
      logic            latch;
      logic [NFLT-2:0] cause;
      logic            overTemp;
      logic [1:0]      lowSync;
      logic [NFLT-1:0] prevLive;
      logic [7:0]      temp1;
      logic [7:0]      temp2;
      logic [1:0]      modeSync;
      logic [1:0]      doneSync;
      logic            battPrev;
      logic            battMsg;
      logic            swRestart;
      afi_mode_e       mode;
      logic            awHeld;
      logic [7:0]      awAddr;
      logic            wHeld;
      logic [31:0]     wData;
      logic            bValid;
      logic [1:0]      bResp;
      logic            rValid;
      logic [31:0]     rData;
      logic [1:0]      rResp;
      logic [2:0]      disp;
   } afi_state_s;

endpackage : afi_pkg
